// ### edge_watch.v
// Rising and falling edge detector for a group of event levels
`timescale 1ns/1ns
module edge_watch #(
    parameter W = 1
) (
    clk_sys,
    rst_n,
    sig,
    rise,
    fall
);
    input wire clk_sys;
    input wire rst_n;
    input wire [W-1:0] sig;
    output wire [W-1:0] rise;
    output wire [W-1:0] fall;

    reg [W-1:0] prev_reg;
    reg primed_reg;

    // First sample after reset only primes, so no false edge
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            prev_reg <= {W{1'b0}};
            primed_reg <= 1'b0;
        end else begin
            prev_reg <= sig;
            primed_reg <= 1'b1;
        end
    end

    assign rise = sig & ~prev_reg & {W{primed_reg}};
    assign fall = ~sig & prev_reg & {W{primed_reg}};
endmodule // edge_watch

// ### flag_bank.v
// Sticky status flags, set by hardware, cleared by writing ones
`timescale 1ns/1ns
module flag_bank #(
    parameter W = 1
) (
    clk_sys,
    rst_n,
    set,
    clr,
    flags
);
    input wire clk_sys;
    input wire rst_n;
    input wire [W-1:0] set;
    input wire [W-1:0] clr;
    output reg [W-1:0] flags;

    // Set wins over a clear in the same cycle, so no event is lost
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            flags <= {W{1'b0}};
        end else begin
            flags <= (flags & ~clr) | set;
        end
    end
endmodule // flag_bank

// ### meter_irq_defs.vh
// Register indexes, field positions and reset values of the mask block
`ifndef METER_IRQ_DEFS_VH
`define METER_IRQ_DEFS_VH

// Register indexes; byte address is four times the index
`define IDX_MASK_PRI 16'he50a
`define IDX_MASK_SEC 16'he50b
`define IDX_STAT_PRI 16'he500
`define IDX_STAT_SEC 16'he501
`define IDX_MEAS_MODE 16'he502
`define IDX_PMODE 16'he503

// Primary mask and status field positions
`define PRI_REVRP_C 12
`define PRI_PSUM2 13
`define PRI_PULSE1 14
`define PRI_PULSE2 15
`define PRI_PULSE3 16
`define PRI_DONE 17
`define PRI_PSUM3 18
`define PRI_LSB 12
`define PRI_MSB 18

// Secondary mask and status field positions
`define SEC_NL_TOT 0
`define SEC_NL_FUND 1
`define SEC_NL_APP 2
`define SEC_ZXTO_V_LSB 3
`define SEC_ZXTO_I_LSB 6
`define SEC_ZX_V_LSB 9
`define SEC_ZX_I_LSB 12
`define SEC_MSB 14

// Measurement mode and pulse output mode fields
`define MEAS_MODE_RP_SEL 1
`define MEAS_MODE_MSB 1
`define PMODE_SEL1_LSB 0
`define PMODE_SEL2_LSB 3
`define PMODE_SEL3_LSB 6
`define PMODE_DIS1 9
`define PMODE_DIS2 10
`define PMODE_DIS3 11
`define PMODE_MSB 11

// Reset values
`define RST_MASK_PRI 7'h00
`define RST_MASK_SEC 15'h0000
`define RST_MEAS_MODE 2'h0
`define RST_PMODE 12'h000

`endif

// ### metering_interrupt_mask_logic.v
// Interrupt mask registers, event flags and request of the metering core
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ns
`include "meter_irq_defs.vh"

// Function
// - Mask bit 12 enables phase C reactive sign
// - Mask bit 13 enables path two sign
// - Mask bit 14 enables pulse one falling
// - Mask bit 15 enables pulse two falling
// - Mask bit 16 enables pulse three falling
// - Pulse interrupts work with pin disabled
// - Three-bit fields select each pulse power
// - Mask bit 17 enables computation cycle done
// - Mask bit 18 enables path three sign
// - Primary bits 31 to 19 reserved zero
// - Secondary bit 0 enables total no-load
// - Secondary bit 1 enables fundamental no-load
// - Secondary bit 2 enables apparent no-load
// - Bits 3-5 enable voltage crossing timeouts
// - Bits 6-8 enable current crossing timeouts
// - Bits 9-11 enable voltage crossings
// - Bits 12-14 enable current crossings
module metering_interrupt_mask_logic (
    input wire clk_sys,
    input wire rst_n,
    input wire [17:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire phase_c_reactive_total_sign,
    input wire phase_c_reactive_fund_sign,
    input wire pulse_path2_sum_sign,
    input wire pulse_path3_sum_sign,
    input wire pulse_raw_one,
    input wire pulse_raw_two,
    input wire pulse_raw_three,
    input wire compute_cycle_done,
    input wire [2:0] total_noload_phase,
    input wire [2:0] fundamental_noload_phase,
    input wire [2:0] apparent_noload_phase,
    input wire [2:0] volt_crossing_timeout,
    input wire [2:0] curr_crossing_timeout,
    input wire [2:0] volt_crossing,
    input wire [2:0] curr_crossing,
    output reg energy_pulse_out_one,
    output reg energy_pulse_out_two,
    output reg energy_pulse_out_three,
    output wire [2:0] pulse_out_one_power_sel,
    output wire [2:0] pulse_out_two_power_sel,
    output wire [2:0] pulse_out_three_power_sel,
    output reg irq_n
);

    ////////////////////////////////////////////////////////////////////
    // Register storage

    reg [`PRI_MSB:`PRI_LSB] mask_pri_reg;
    reg [`SEC_MSB:0] mask_sec_reg;
    reg [`MEAS_MODE_MSB:0] measurement_mode_reg;
    reg [`PMODE_MSB:0] pmode_reg;
    reg ack_reg;
    reg [31:0] rdata_next;
    reg [31:0] wmask;
    reg [31:0] wval;

    wire [`PRI_MSB:`PRI_LSB] stat_pri;
    wire [`SEC_MSB:0] stat_sec;
    wire [15:0] word_idx;
    wire aligned;
    wire acc;
    wire wr_take;
    wire hit_mask_pri;
    wire hit_mask_sec;
    wire hit_stat_pri;
    wire hit_stat_sec;
    wire hit_meas_mode;
    wire hit_pmode;

    ////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: every access waits exactly one cycle

    // Word index in the upper address bits, low two bits must be zero
    assign word_idx = avs_address[17:2];
    assign aligned = (avs_address[1:0] == 2'h0);
    assign acc = avs_read | avs_write;
    assign hit_mask_pri = aligned & (word_idx == `IDX_MASK_PRI);
    assign hit_mask_sec = aligned & (word_idx == `IDX_MASK_SEC);
    assign hit_stat_pri = aligned & (word_idx == `IDX_STAT_PRI);
    assign hit_stat_sec = aligned & (word_idx == `IDX_STAT_SEC);
    assign hit_meas_mode = aligned & (word_idx == `IDX_MEAS_MODE);
    assign hit_pmode = aligned & (word_idx == `IDX_PMODE);

    // Wait is high in the first cycle, low in the second
    assign avs_waitrequest = acc & ~ack_reg;
    // Write lands only at the edge where wait is low
    assign wr_take = avs_write & ack_reg;

    // Ack toggles so back-to-back accesses each get one wait cycle
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= acc & ~ack_reg;
        end
    end

    // Byte enables expanded to a bit mask
    always @* begin
        wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        wval = avs_writedata & wmask;
    end

    // Read mux; unmapped or misaligned addresses read as zero
    always @* begin
        rdata_next = 32'h00000000;
        if (hit_mask_pri) begin
            rdata_next[`PRI_MSB:`PRI_LSB] = mask_pri_reg;
        end else if (hit_mask_sec) begin
            rdata_next[`SEC_MSB:0] = mask_sec_reg;
        end else if (hit_stat_pri) begin
            rdata_next[`PRI_MSB:`PRI_LSB] = stat_pri;
        end else if (hit_stat_sec) begin
            rdata_next[`SEC_MSB:0] = stat_sec;
        end else if (hit_meas_mode) begin
            rdata_next[`MEAS_MODE_MSB:0] = measurement_mode_reg;
        end else if (hit_pmode) begin
            rdata_next[`PMODE_MSB:0] = pmode_reg;
        end
    end

    // Read data captured in the wait cycle, stands at the answer edge
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read & ~ack_reg) begin
            avs_readdata <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control registers

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            mask_pri_reg <= `RST_MASK_PRI;
            mask_sec_reg <= `RST_MASK_SEC;
            measurement_mode_reg <= `RST_MEAS_MODE;
            pmode_reg <= `RST_PMODE;
        end else if (wr_take) begin
            // only bits 18 to 12 stored
            if (hit_mask_pri) begin
                mask_pri_reg <= (mask_pri_reg &
                                 ~wmask[`PRI_MSB:`PRI_LSB]) |
                                wval[`PRI_MSB:`PRI_LSB];
            end
            if (hit_mask_sec) begin
                mask_sec_reg <= (mask_sec_reg & ~wmask[`SEC_MSB:0]) |
                                wval[`SEC_MSB:0];
            end
            if (hit_meas_mode) begin
                measurement_mode_reg <= (measurement_mode_reg &
                                         ~wmask[`MEAS_MODE_MSB:0]) |
                                        wval[`MEAS_MODE_MSB:0];
            end
            if (hit_pmode) begin
                pmode_reg <= (pmode_reg & ~wmask[`PMODE_MSB:0]) |
                             wval[`PMODE_MSB:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Event detection

    wire rp_sign_sel;
    wire [2:0] sign_in;
    wire [2:0] sign_rise;
    wire [2:0] sign_fall;
    wire [2:0] pulse_in;
    wire [2:0] pulse_rise;
    wire [2:0] pulse_fall;
    wire [2:0] nl_rise;
    wire [2:0] tot_rise;
    wire [2:0] fund_rise;
    wire [2:0] app_rise;

    // reactive source chosen by mode bit
    assign rp_sign_sel = measurement_mode_reg[`MEAS_MODE_RP_SEL] ?
                         phase_c_reactive_fund_sign :
                         phase_c_reactive_total_sign;
    // Select change also registers as a sign change, by design
    assign sign_in = {pulse_path3_sum_sign, pulse_path2_sum_sign,
                      rp_sign_sel};

    // Sign change is either edge of the sign level
    edge_watch #(.W(3)) u_sign_edges (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sig(sign_in),
        .rise(sign_rise),
        .fall(sign_fall)
    );

    // raw pulses watched, ahead of the disable gate
    assign pulse_in = {pulse_raw_three, pulse_raw_two, pulse_raw_one};

    edge_watch #(.W(3)) u_pulse_edges (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sig(pulse_in),
        .rise(pulse_rise),
        .fall(pulse_fall)
    );

    // Per-phase no-load entry; any phase entering counts
    edge_watch #(.W(3)) u_nl_tot (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sig(total_noload_phase),
        .rise(tot_rise),
        .fall()
    );

    edge_watch #(.W(3)) u_nl_fund (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sig(fundamental_noload_phase),
        .rise(fund_rise),
        .fall()
    );

    edge_watch #(.W(3)) u_nl_app (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sig(apparent_noload_phase),
        .rise(app_rise),
        .fall()
    );

    assign nl_rise = {|app_rise, |fund_rise, |tot_rise};

    ////////////////////////////////////////////////////////////////////
    // Status flags

    reg [`PRI_MSB:`PRI_LSB] set_pri;
    reg [`SEC_MSB:0] set_sec;
    wire [`PRI_MSB:`PRI_LSB] clr_pri;
    wire [`SEC_MSB:0] clr_sec;

    // Primary event sources
    always @* begin
        set_pri = 7'h00;
        set_pri[`PRI_REVRP_C] = sign_rise[0] | sign_fall[0];
        set_pri[`PRI_PSUM2] = sign_rise[1] | sign_fall[1];
        set_pri[`PRI_PULSE1] = pulse_fall[0];
        set_pri[`PRI_PULSE2] = pulse_fall[1];
        set_pri[`PRI_PULSE3] = pulse_fall[2];
        set_pri[`PRI_DONE] = compute_cycle_done;
        set_pri[`PRI_PSUM3] = sign_rise[2] | sign_fall[2];
    end

    // Secondary event sources
    always @* begin
        set_sec = 15'h0000;
        set_sec[`SEC_NL_TOT] = nl_rise[0];
        set_sec[`SEC_NL_FUND] = nl_rise[1];
        set_sec[`SEC_NL_APP] = nl_rise[2];
        set_sec[`SEC_ZXTO_V_LSB+2:`SEC_ZXTO_V_LSB] = volt_crossing_timeout;
        set_sec[`SEC_ZXTO_I_LSB+2:`SEC_ZXTO_I_LSB] = curr_crossing_timeout;
        set_sec[`SEC_ZX_V_LSB+2:`SEC_ZX_V_LSB] = volt_crossing;
        set_sec[`SEC_ZX_I_LSB+2:`SEC_ZX_I_LSB] = curr_crossing;
    end

    // Write one to clear, at the answer edge only
    assign clr_pri = (wr_take & hit_stat_pri) ?
                     wval[`PRI_MSB:`PRI_LSB] : 7'h00;
    assign clr_sec = (wr_take & hit_stat_sec) ?
                     wval[`SEC_MSB:0] : 15'h0000;

    flag_bank #(.W(7)) u_stat_pri (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .set(set_pri),
        .clr(clr_pri),
        .flags(stat_pri)
    );

    flag_bank #(.W(15)) u_stat_sec (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .set(set_sec),
        .clr(clr_sec),
        .flags(stat_sec)
    );

    ////////////////////////////////////////////////////////////////////
    // Request and pulse pins

    // active-low request while any enabled flag stands
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= ~(|(stat_pri & mask_pri_reg) |
                       |(stat_sec & mask_sec_reg));
        end
    end

    // disabled pin idles high, flag path unaffected
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            energy_pulse_out_one <= 1'b1;
            energy_pulse_out_two <= 1'b1;
            energy_pulse_out_three <= 1'b1;
        end else begin
            energy_pulse_out_one <= pulse_raw_one |
                                    pmode_reg[`PMODE_DIS1];
            energy_pulse_out_two <= pulse_raw_two |
                                    pmode_reg[`PMODE_DIS2];
            energy_pulse_out_three <= pulse_raw_three |
                                      pmode_reg[`PMODE_DIS3];
        end
    end

    // power select fields to the pulse generators
    assign pulse_out_one_power_sel =
        pmode_reg[`PMODE_SEL1_LSB+2:`PMODE_SEL1_LSB];
    assign pulse_out_two_power_sel =
        pmode_reg[`PMODE_SEL2_LSB+2:`PMODE_SEL2_LSB];
    assign pulse_out_three_power_sel =
        pmode_reg[`PMODE_SEL3_LSB+2:`PMODE_SEL3_LSB];

endmodule // metering_interrupt_mask_logic

// ### metering_irq_chk.sv
// Checker of bus handshake, pulse pin one and request of the mask block
`timescale 1ns/1ns
module metering_irq_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [17:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic pulse_raw_one,
    input wire logic energy_pulse_out_one,
    input wire logic [2:0] pulse_out_one_power_sel,
    input wire logic irq_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // Accepted transfers and the decoded register window
    wire rd_ok = avs_read && !avs_waitrequest;
    wire wr_ok = avs_write && !avs_waitrequest;
    wire mapped = avs_address[1:0] == 2'h0 &&
        (avs_address[17:4] == 14'h3940 || avs_address[17:3] == 15'h7285);
    ////////////////////////////////////////////////////////////////////////
    chk_wait_first: assert property ($rose(avs_read) |-> avs_waitrequest)
        else $error("read answered with no wait state");
    chk_wait_one: assert property (avs_waitrequest |=> !avs_waitrequest)
        else $error("wait state longer than one cycle");
    chk_unmapped_zero: assert property (rd_ok && !mapped |-> avs_readdata == 0)
        else $error("unmapped read not zero");
    chk_pri_reserved: assert property (
        rd_ok && avs_address == 18'h39428 |->
        avs_readdata[31:19] == 0 && avs_readdata[11:0] == 0)
        else $error("reserved primary mask bits read nonzero");
    chk_pulse_idle: assert property (
        pulse_raw_one |=> energy_pulse_out_one)
        else $error("pulse pin low with raw pulse idle");
    chk_pulse_fall: assert property (
        $fell(energy_pulse_out_one) |-> !$past(pulse_raw_one))
        else $error("pulse pin fell without raw pulse");
    chk_sel_write: assert property (
        !$stable(pulse_out_one_power_sel) |-> $past(wr_ok))
        else $error("power select changed without write");
    // A request only drops after software writes a clear or a mask
    chk_irq_clear: assert property (
        $rose(irq_n) |-> $past(wr_ok) || $past(wr_ok, 2) || $past(wr_ok, 3))
        else $error("request released without a write");
    cover property ($fell(irq_n));
    cover property (rd_ok && mapped);
    cover property ($fell(energy_pulse_out_one));
endmodule // metering_irq_chk

// ### tb_top.sv
// Self-checking bench of the interrupt mask block
`timescale 1ns/1ns
module tb_top;
    localparam logic [17:0] A_MP = 18'h39428;
    localparam logic [17:0] A_MS = 18'h3942c;
    localparam logic [17:0] A_SP = 18'h39400;
    localparam logic [17:0] A_SS = 18'h39404;
    localparam logic [17:0] A_MM = 18'h39408;
    localparam logic [17:0] A_PM = 18'h3940c;
    logic clk_sys, rst_n, avs_read, avs_write, done;
    logic [17:0] avs_address;
    logic [31:0] avs_writedata, rd;
    logic [3:0] be, sg;
    logic [2:0] raw;
    logic [8:0] nl;
    logic [11:0] pz;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, irq_n;
    wire [2:0] pout;
    wire [8:0] psel;
    int failures, comparisons;
    ////////////////////////////////////////////////////////////////////////
    metering_interrupt_mask_logic dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(be),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .phase_c_reactive_total_sign(sg[0]),
        .phase_c_reactive_fund_sign(sg[1]),
        .pulse_path2_sum_sign(sg[2]), .pulse_path3_sum_sign(sg[3]),
        .pulse_raw_one(raw[0]), .pulse_raw_two(raw[1]),
        .pulse_raw_three(raw[2]), .compute_cycle_done(done),
        .total_noload_phase(nl[2:0]), .fundamental_noload_phase(nl[5:3]),
        .apparent_noload_phase(nl[8:6]), .volt_crossing_timeout(pz[2:0]),
        .curr_crossing_timeout(pz[5:3]), .volt_crossing(pz[8:6]),
        .curr_crossing(pz[11:9]), .energy_pulse_out_one(pout[0]),
        .energy_pulse_out_two(pout[1]), .energy_pulse_out_three(pout[2]),
        .pulse_out_one_power_sel(psel[2:0]),
        .pulse_out_two_power_sel(psel[5:3]),
        .pulse_out_three_power_sel(psel[8:6]), .irq_n(irq_n));
    ////////////////////////////////////////////////////////////////////////
    // Comparison and bus tasks
    task chk_word(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task chk_bit(input logic g, input logic e);
        chk_word({31'h0, g}, {31'h0, e});
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Request held until waitrequest is seen low at an edge
    task xfer(input logic r, input logic [17:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        avs_read <= r;
        avs_write <= !r;
        avs_address <= a;
        avs_writedata <= d;
        n = 0;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            n++;
            @(posedge clk_sys);
        end
        if (n == 50) begin
            failures++;
            give_verdict;
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task wr(input logic [17:0] a, input logic [31:0] d);
        xfer(1'b0, a, d);
    endtask
    task rdchk(input logic [17:0] a, input logic [31:0] e);
        xfer(1'b1, a, 32'h0);
        chk_word(rd, e);
    endtask
    // Raise event k: 0-6 primary bits 12-18, 7-21 secondary bits 0-14
    task fire(input int k);
        @(posedge clk_sys);
        case (k)
            0: sg[0] <= ~sg[0];
            1: sg[2] <= ~sg[2];
            2, 3, 4: raw[k-2] <= 1'b0;
            5: done <= 1'b1;
            6: sg[3] <= ~sg[3];
            7, 8, 9: nl[(k-7)*4] <= 1'b1;
            default: pz[k-10] <= 1'b1;
        endcase
        @(posedge clk_sys);
        raw <= 3'h7;
        done <= 1'b0;
        nl <= 9'h0;
        pz <= 12'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Reset values, reserved bits, lanes and unmapped places
    task t_regs;
        chk_bit(irq_n, 1'b1);
        chk_word({23'h0, psel}, 32'h0);
        rdchk(A_MP, 32'h0);
        rdchk(A_MS, 32'h0);
        wr(A_MP, 32'hffffffff);
        rdchk(A_MP, 32'h0007f000);
        wr(A_MS, 32'hffffffff);
        rdchk(A_MS, 32'h00007fff);
        wr(A_MP, 32'h0);
        be <= 4'h2;
        wr(A_MP, 32'hffffffff);
        be <= 4'hf;
        rdchk(A_MP, 32'h0000f000);
        wr(18'h39410, 32'hffffffff);
        rdchk(18'h39410, 32'h0);
        rdchk(18'h3942a, 32'h0);
        wr(A_MP, 32'h0);
        wr(A_MS, 32'h0);
    endtask
    // Fundamental source chosen: total sign change must not count
    task t_react;
        wr(A_MM, 32'h2);
        wr(A_SP, 32'hffffffff);
        wr(A_MP, 32'h00001000);
        fire(0);
        cyc(4);
        chk_bit(irq_n, 1'b1);
        rdchk(A_MM, 32'h2);
        @(posedge clk_sys);
        sg[1] <= ~sg[1];
        cyc(4);
        chk_bit(irq_n, 1'b0);
        wr(A_MM, 32'h0);
        wr(A_SP, 32'hffffffff);
        wr(A_MP, 32'h0);
    endtask
    // Pins one and three disabled still flag; pin two pulses on its pin
    task t_pulse;
        wr(A_PM, 32'h00000abd);
        rdchk(A_PM, 32'h00000abd);
        chk_word({23'h0, psel}, 32'h000000bd);
        wr(A_MP, 32'h0000c000);
        @(posedge clk_sys);
        raw <= 3'h0;
        cyc(2);
        chk_bit(pout[0], 1'b1);
        chk_bit(pout[1], 1'b0);
        chk_bit(pout[2], 1'b1);
        raw <= 3'h7;
        cyc(3);
        chk_bit(irq_n, 1'b0);
        rdchk(A_SP, 32'h0001c000);
        wr(A_SP, 32'h0001c000);
        wr(A_MP, 32'h0);
        wr(A_PM, 32'h0);
    endtask
    // Each event: flagged while masked, requests once enabled
    task t_event(input int k);
        logic [17:0] ma, sa;
        logic [31:0] b;
        ma = k < 7 ? A_MP : A_MS;
        sa = k < 7 ? A_SP : A_SS;
        b = k < 7 ? 32'h1 << (12 + k) : 32'h1 << (k - 7);
        fire(k);
        cyc(4);
        chk_bit(irq_n, 1'b1);
        rdchk(sa, b);
        wr(ma, b);
        cyc(3);
        chk_bit(irq_n, 1'b0);
        wr(sa, b);
        cyc(3);
        chk_bit(irq_n, 1'b1);
        fire(k);
        cyc(4);
        chk_bit(irq_n, 1'b0);
        wr(sa, b);
        wr(ma, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task give_verdict;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Clock, 100 ns period
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Hang guard, far beyond the expected run
    initial begin
        #2000000;
        failures++;
        give_verdict;
    end
    // Main sequence
    initial begin
        failures = 0;
        comparisons = 0;
        rst_n = 1'b0;
        {avs_read, avs_write, done} = 3'h0;
        avs_address = 18'h0;
        avs_writedata = 32'h0;
        be = 4'hf;
        sg = 4'h0;
        raw = 3'h7;
        nl = 9'h0;
        pz = 12'h0;
        cyc(10);
        rst_n <= 1'b1;
        t_regs;
        t_react;
        t_pulse;
        for (int k = 0; k < 22; k++) t_event(k);
        give_verdict;
    end
endmodule // tb_top

bind metering_interrupt_mask_logic metering_irq_chk chk_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pulse_raw_one(pulse_raw_one),
    .energy_pulse_out_one(energy_pulse_out_one),
    .pulse_out_one_power_sel(pulse_out_one_power_sel), .irq_n(irq_n));
